/* File: hw/ir_key_scan_tx.sv */
// Key matrix scanner and code sequencer of an infrared remote transmitter.
// Assumes all pins synchronous to hclk and one AHB-Lite master.
//
// Functional notes
// - Mode select low gives combined system mode, high gives single system mode.
// - Sense inputs pulled high internally; a pressed key reads low via a strobe.
// - One legal key held 18 bit-times completes debounce and latches oscillator hold.
// - Contact lost before 18 bit-times returns the sequencer to idle; latches and toggle bit keep their values.
// - After debounce strobes go off, then two scans step strobes one at a time.
// - Low sense in scan loads system latch (system group) or command latch.
// - System only latched: send all-ones command while key stays held.
// - Command latched: send it with the latched system number.
// - Release resets unless a code is being sent; a started code finishes.
// - Single mode: system pull-ups off, wired link gives system, command keys debounce.
// - Single mode first scan: command pull-ups off, system on, wired link latched.
// - Single mode second scan: command pull-ups back, command latched and sent.
// - Toggle bit inverts on release only after at least one full code.
// - Both scans repeat before every code so a taken-over key is right.
// - Release in debounce or between codes resets at once.
// - Scan release resets if key unseen, or no wired link in single mode.
// - Both test inputs and resonator pin high initialise all but the latches.
// - Scan speed-up input makes scanning 24 times faster after debounce.
// - Readout speed-up input makes code shifting 384 times faster after scan.
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ir_key_scan_tx #(
    parameter int BIT_CYCLES = ir_key_scan_pkg::DEFAULT_BIT_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic system_mode_select,
    input wire logic scan_speedup_test,
    input wire logic latch_readout_speedup_test,
    input wire logic resonator_pin,
    input wire logic [ir_key_scan_pkg::NUM_CMD_SENSE-1:0] cmd_sense,
    input wire logic [ir_key_scan_pkg::NUM_SYS_SENSE-1:0] sys_sense,
    input wire logic [ir_key_scan_pkg::NUM_STROBES-1:0] scan_strobe_outputs_in,
    output logic [ir_key_scan_pkg::NUM_STROBES-1:0] scan_strobe_outputs_out,
    output logic [ir_key_scan_pkg::NUM_STROBES-1:0] scan_strobe_outputs_oe,
    output logic cmd_pullup_en,
    output logic sys_pullup_en,
    output logic osc_hold,
    output logic data_out,
    output logic carrier_modulated_output
);
    import ir_key_scan_pkg::*;

    if (BIT_CYCLES < 2 * READOUT_FAST_DIV || BIT_CYCLES % (2 * READOUT_FAST_DIV) != 0 || BIT_CYCLES > 65535) begin
        $error("BIT_CYCLES must be a multiple of twice the readout speed-up factor");
    end

    localparam logic [15:0] BIT_SLOW = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] BIT_FAST = 16'(BIT_CYCLES / SCAN_FAST_DIV - 1);
    localparam logic [5:0] DEBOUNCE_LAST = 6'(DEBOUNCE_BITS - 1);
    localparam logic [5:0] GAP_LAST = 6'(GAP_BITS - 1);
    localparam logic [2:0] STEP_LAST = 3'(NUM_STROBES - 1);
    localparam logic [3:0] CARRIER_LAST = 4'(CARRIER_PERIOD - 1);
    localparam logic [3:0] CARRIER_ON = 4'(CARRIER_HIGH);

    ////////////////////////////////////////////////////////////////////////////
    // State
    state_type state_r;
    state_type state_nxt;
    logic [15:0] bit_cnt_r;
    logic [5:0] bits_r;
    logic [2:0] step_r;
    logic pass_r;
    logic [4:0] sys_latch_r;
    logic [5:0] cmd_latch_r;
    logic sys_found_r;
    logic cmd_found_r;
    logic toggle_r;
    logic sent_once_r;
    logic osc_hold_r;
    logic tx_start_r;
    logic [3:0] car_cnt_r;
    logic mod_r;
    logic enable_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] hrdata_r;
    code_word_type last_code_r;
    logic tx_busy;
    logic tx_done;
    logic tx_data;

    ////////////////////////////////////////////////////////////////////////////
    // Encoder of the lowest asserted line
    function automatic logic [2:0] low_index(input logic [7:0] lows);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NUM_STROBES - 1; i >= 0; i--) begin
            if (lows[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pull-ups and sense decoding
    wire single_mode = system_mode_select;
    wire first_pass = (state_r == ST_SCAN) && !pass_r;
    wire sys_pu = single_mode ? first_pass : 1'b1;
    wire cmd_pu = single_mode ? !first_pass : 1'b1;
    wire [7:0] cmd_low = ~cmd_sense & {NUM_CMD_SENSE{cmd_pu}};
    wire [3:0] sys_low = ~sys_sense & {NUM_SYS_SENSE{sys_pu}};
    wire [11:0] all_low = {sys_low, cmd_low};
    wire any_press = |all_low;
    wire legal_press = ($countones(all_low) == 1);
    wire test_init = scan_speedup_test && latch_readout_speedup_test && resonator_pin;
    wire hold_idle = test_init || !enable_r;

    ////////////////////////////////////////////////////////////////////////////
    // Bit-time ticks
    wire scanning = (state_r == ST_SCAN);
    wire [15:0] bit_last = (scanning && scan_speedup_test) ? BIT_FAST : BIT_SLOW;
    wire bit_tick = (bit_cnt_r == bit_last);
    wire state_change = (state_nxt != state_r);

    ////////////////////////////////////////////////////////////////////////////
    // Scan hits on the active strobe
    wire strobe_seen = !scan_strobe_outputs_in[step_r];
    wire sample = scanning && bit_tick && strobe_seen;
    wire sys_hit = sample && (|sys_low);
    wire cmd_hit = sample && (|cmd_low);
    wire step_end = scanning && bit_tick && (step_r == STEP_LAST);
    wire sys_seen = sys_found_r || sys_hit;
    wire cmd_seen = cmd_found_r || cmd_hit;
    wire link_missing = single_mode && !pass_r && !sys_seen;
    wire key_unseen = pass_r && (single_mode ? !cmd_seen : !(cmd_seen || sys_seen));
    wire scan_fail = link_missing || key_unseen;
    wire [2:0] sys_idx = low_index({4'h0, sys_low});
    wire [4:0] sys_code = {sys_idx[1:0], step_r};
    wire [5:0] cmd_code = {low_index(cmd_low), step_r};
    wire [5:0] cmd_sent = cmd_found_r ? cmd_latch_r : ALL_ONES_CMD;
    wire code_word_type tx_code = '{toggle: toggle_r, system: sys_latch_r, command: cmd_sent};
    wire going_idle = (state_nxt == ST_IDLE) && (state_r != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (legal_press) begin
                    state_nxt = ST_DEBOUNCE;
                end
            end
            ST_DEBOUNCE: begin
                if (!legal_press) begin
                    state_nxt = ST_IDLE;
                end else if (bit_tick && bits_r == DEBOUNCE_LAST) begin
                    state_nxt = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (step_end) begin
                    if (scan_fail) begin
                        state_nxt = ST_IDLE;
                    end else if (pass_r) begin
                        state_nxt = ST_TX;
                    end
                end
            end
            ST_TX: begin
                if (tx_done) begin
                    state_nxt = ST_GAP;
                end
            end
            ST_GAP: begin
                if (!any_press) begin
                    state_nxt = ST_IDLE;
                end else if (bit_tick && bits_r == GAP_LAST) begin
                    state_nxt = ST_SCAN;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (hold_idle) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 16'h0000;
            bits_r <= 6'h00;
        end else if (clk_en) begin
            state_r <= state_nxt;
            bit_cnt_r <= (state_change || bit_tick) ? 16'h0000 : bit_cnt_r + 16'h0001;
            if (state_change) begin
                bits_r <= 6'h00;
            end else if (bit_tick) begin
                bits_r <= bits_r + 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scan step and pass
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_r <= 3'h0;
            pass_r <= 1'b0;
            sys_found_r <= 1'b0;
            cmd_found_r <= 1'b0;
        end else if (clk_en) begin
            if (!scanning || state_change) begin
                step_r <= 3'h0;
                pass_r <= 1'b0;
                if (state_nxt == ST_SCAN) begin
                    sys_found_r <= 1'b0;
                    cmd_found_r <= 1'b0;
                end
            end else if (bit_tick) begin
                step_r <= step_r + 3'h1;
                if (step_r == STEP_LAST) begin
                    pass_r <= 1'b1;
                end
                sys_found_r <= sys_seen;
                cmd_found_r <= cmd_seen;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System and command latches, left alone by test initialisation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_latch_r <= 5'h00;
            cmd_latch_r <= 6'h00;
        end else if (clk_en) begin
            if (sys_hit) begin
                sys_latch_r <= sys_code;
            end
            if (cmd_hit) begin
                cmd_latch_r <= cmd_code;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Toggle, oscillator hold and transmit start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            toggle_r <= 1'b0;
            sent_once_r <= 1'b0;
            osc_hold_r <= 1'b0;
            tx_start_r <= 1'b0;
            last_code_r <= '0;
        end else if (clk_en) begin
            tx_start_r <= (state_r == ST_SCAN) && (state_nxt == ST_TX);
            if (tx_start_r) begin
                last_code_r <= tx_code;
            end
            if (test_init) begin
                toggle_r <= 1'b0;
                sent_once_r <= 1'b0;
                osc_hold_r <= 1'b0;
            end else if (going_idle) begin
                toggle_r <= toggle_r ^ sent_once_r;
                sent_once_r <= 1'b0;
                osc_hold_r <= 1'b0;
            end else begin
                if (tx_done) begin
                    sent_once_r <= 1'b1;
                end
                if (state_r == ST_DEBOUNCE && state_nxt == ST_SCAN) begin
                    osc_hold_r <= 1'b1;
                end
            end
        end
    end

    biphase_serializer #(
        .HALF_CYCLES(BIT_CYCLES / 2)
    ) u_serializer (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .abort(hold_idle),
        .start(tx_start_r),
        .fast(latch_readout_speedup_test),
        .code(tx_code),
        .busy(tx_busy),
        .done(tx_done),
        .data_out(tx_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Carrier modulation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            car_cnt_r <= 4'h0;
            mod_r <= 1'b0;
        end else if (clk_en) begin
            car_cnt_r <= (car_cnt_r == CARRIER_LAST) ? 4'h0 : car_cnt_r + 4'h1;
            mod_r <= tx_data && (car_cnt_r < CARRIER_ON);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobe drivers: all low while waiting, one at a time while scanning
    for (genvar i = 0; i < NUM_STROBES; i++) begin : g_strobe
        assign scan_strobe_outputs_out[i] = 1'b0;
        assign scan_strobe_outputs_oe[i] = scanning ? (step_r == 3'(i)) : (state_r != ST_TX);
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states
    wire ahb_take = hsel && hready && htrans[1];
    wire [7:0] rd_addr = haddr[7:0];
    wire upper_zero = (haddr[31:8] == 24'h000000);
    wire [31:0] status_word = {24'h000000, tx_busy, sent_once_r, single_mode, osc_hold_r, toggle_r, state_r};
    wire [31:0] ctrl_word = {31'h00000000, enable_r};
    wire [31:0] code_word = {20'h00000, last_code_r};
    wire [31:0] rd_value = !upper_zero ? 32'h00000000 :
                           (rd_addr == ADDR_CTRL) ? ctrl_word :
                           (rd_addr == ADDR_STATUS) ? status_word :
                           (rd_addr == ADDR_CODE) ? code_word : 32'h00000000;
    wire wr_ok = ahb_take && hwrite && (hsize == HSIZE_WORD) && upper_zero;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h00000000;
            enable_r <= CTRL_ENABLE_RESET;
        end else if (clk_en) begin
            wr_pend_r <= wr_ok;
            if (ahb_take) begin
                wr_addr_r <= rd_addr;
            end
            if (ahb_take && !hwrite) begin
                hrdata_r <= rd_value;
            end
            if (wr_pend_r && wr_addr_r == ADDR_CTRL) begin
                enable_r <= hwdata[CTRL_ENABLE_BIT];
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign cmd_pullup_en = cmd_pu;
    assign sys_pullup_en = sys_pu;
    assign osc_hold = osc_hold_r;
    assign data_out = tx_data;
    assign carrier_modulated_output = mod_r;

endmodule

/* File: hw/ir_key_scan_pkg.sv */
// Shared constants, carriers and states of the remote-control key scanner.
// Assumes a single 40 MHz clock that stands in for the resonator clock.
package ir_key_scan_pkg;

    localparam int NUM_STROBES = 8;
    localparam int NUM_CMD_SENSE = 8;
    localparam int NUM_SYS_SENSE = 4;
    localparam int CODE_BITS = 12;

    // Timing counts, in bit-times or clock cycles
    localparam int DEBOUNCE_BITS = 18;
    localparam int GAP_BITS = 50;
    localparam int SCAN_FAST_DIV = 24;
    localparam int READOUT_FAST_DIV = 384;
    localparam int DEFAULT_BIT_CYCLES = 768;
    localparam int CARRIER_PERIOD = 12;
    localparam int CARRIER_HIGH = 3;

    // Register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CODE = 8'h08;

    // Field positions and reset values
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_TOGGLE_BIT = 3;
    localparam int STATUS_OSC_BIT = 4;
    localparam int STATUS_MODE_BIT = 5;
    localparam int STATUS_SENT_BIT = 6;
    localparam int STATUS_BUSY_BIT = 7;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [5:0] ALL_ONES_CMD = 6'h3F;

    typedef struct packed {
        logic toggle;
        logic [4:0] system;
        logic [5:0] command;
    } code_word_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEBOUNCE = 3'b001,
        ST_SCAN = 3'b010,
        ST_TX = 3'b011,
        ST_GAP = 3'b100
    } state_type;

endpackage

/* File: hw/biphase_serializer.sv */
// Biphase serializer for one code word, most significant bit first.
// Assumes start is a one-cycle pulse and code is stable while busy.
`timescale 1ns/1ps
module biphase_serializer #(
    parameter int HALF_CYCLES = 384
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic abort,
    input wire logic start,
    input wire logic fast,
    input wire ir_key_scan_pkg::code_word_type code,
    output logic busy,
    output logic done,
    output logic data_out
);
    import ir_key_scan_pkg::*;

    if (HALF_CYCLES < READOUT_FAST_DIV || HALF_CYCLES % READOUT_FAST_DIV != 0 || HALF_CYCLES > 32768) begin
        $error("HALF_CYCLES must be a multiple of the readout speed-up factor");
    end

    localparam logic [15:0] HALF_SLOW = 16'(HALF_CYCLES - 1);
    localparam logic [15:0] HALF_FAST = 16'(HALF_CYCLES / READOUT_FAST_DIV - 1);
    localparam logic [4:0] LAST_HALF = 5'(2 * CODE_BITS - 1);

    logic [15:0] cnt_r;
    logic [4:0] phase_r;
    logic [CODE_BITS-1:0] shift_r;
    logic busy_r;
    logic done_r;
    logic data_r;

    wire [15:0] half_last = fast ? HALF_FAST : HALF_SLOW;
    wire half_end = busy_r && (cnt_r == half_last);
    wire word_end = half_end && (phase_r == LAST_HALF);

    ////////////////////////////////////////////////////////////////////////////
    // Half-bit timing and shifting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 16'h0000;
            phase_r <= 5'h00;
            shift_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            data_r <= 1'b0;
        end else if (clk_en) begin
            done_r <= word_end;
            if (abort) begin
                busy_r <= 1'b0;
                data_r <= 1'b0;
            end else if (start && !busy_r) begin
                shift_r <= code;
                busy_r <= 1'b1;
                phase_r <= 5'h00;
                cnt_r <= 16'h0000;
                data_r <= ~code[CODE_BITS-1];
            end else if (word_end) begin
                busy_r <= 1'b0;
                data_r <= 1'b0;
            end else if (half_end) begin
                cnt_r <= 16'h0000;
                phase_r <= phase_r + 5'h01;
                if (!phase_r[0]) begin
                    data_r <= shift_r[CODE_BITS-1];
                end else begin
                    shift_r <= {shift_r[CODE_BITS-2:0], 1'b0};
                    data_r <= ~shift_r[CODE_BITS-2];
                end
            end else if (busy_r) begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end

    assign busy = busy_r;
    assign done = done_r;
    assign data_out = data_r;

endmodule

/* File: test/ir_key_scan_props.sv */
// Pin checker for the key scanner.
// Assumes binding into ir_key_scan_tx, port names matching.
`timescale 1ns/1ps
module ir_key_scan_props #(
    parameter int BIT_CYCLES = 768
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic system_mode_select,
    input wire logic scan_speedup_test,
    input wire logic [ir_key_scan_pkg::NUM_STROBES-1:0] scan_strobe_outputs_out,
    input wire logic [ir_key_scan_pkg::NUM_STROBES-1:0] scan_strobe_outputs_oe,
    input wire logic cmd_pullup_en,
    input wire logic sys_pullup_en,
    input wire logic osc_hold,
    input wire logic data_out,
    input wire logic carrier_modulated_output
);
    import ir_key_scan_pkg::*;
    wire logic [NUM_STROBES-1:0] oe = scan_strobe_outputs_oe;
    wire logic in_tx = (oe == '0);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////
    chk_open_drain: assert property (scan_strobe_outputs_out == '0)
        else $error("strobe pin driven high");
    chk_strobe_shape: assert property (&oe || in_tx || $onehot(oe))
        else $error("more than one strobe active in scan");
    chk_step_order: assert property (($onehot(oe) && $onehot($past(oe)) && oe != $past(oe))
        |-> (oe == ($past(oe) << 1) || oe == 8'h01))
        else $error("strobe step out of order");
    chk_step_hold: assert property ((scan_speedup_test && $onehot(oe) && $changed(oe))
        |=> $stable(oe)[*8])
        else $error("scan step too short");
    chk_comb_pullups: assert property (!system_mode_select |-> cmd_pullup_en && sys_pullup_en)
        else $error("pull-up off in combined mode");
    chk_single_excl: assert property (system_mode_select |-> !(cmd_pullup_en && sys_pullup_en))
        else $error("both pull-up groups on in single mode");
    chk_single_idle: assert property (system_mode_select && !$onehot(oe) |-> !sys_pullup_en)
        else $error("system pull-ups on outside first scan");
    chk_scan_hold: assert property ($onehot(oe) |-> ##[0:1] osc_hold)
        else $error("oscillator hold missing in scan");
    chk_data_quiet: assert property ($changed(data_out)
        |-> in_tx || $past(in_tx) || $past(in_tx, 2))
        else $error("serial output moved outside transmission");
    chk_carrier_gate: assert property (carrier_modulated_output |-> $past(data_out))
        else $error("carrier without data");
    cover property ($rose(osc_hold));
    cover property (system_mode_select && sys_pullup_en);
    cover property ($fell(in_tx));
endmodule
bind ir_key_scan_tx ir_key_scan_props #(.BIT_CYCLES(BIT_CYCLES)) i_ir_key_scan_props (.*);

/* File: test/key_matrix_model.sv */
// Key matrix model: one command key and one wired system link.
// Assumes strobe enable high means that strobe pin is pulled low.
`timescale 1ns/1ps
module key_matrix_model (
    input wire logic hclk,
    input wire logic [ir_key_scan_pkg::NUM_STROBES-1:0] strobe_oe,
    input wire logic cmd_pullup_en,
    input wire logic sys_pullup_en,
    input wire logic key_on,
    input wire logic [2:0] key_x,
    input wire logic [2:0] key_s,
    input wire logic link_on,
    input wire logic [1:0] link_z,
    input wire logic [2:0] link_s,
    output logic [ir_key_scan_pkg::NUM_CMD_SENSE-1:0] cmd_sense,
    output logic [ir_key_scan_pkg::NUM_SYS_SENSE-1:0] sys_sense,
    output logic [ir_key_scan_pkg::NUM_STROBES-1:0] strobe_pins
);
    import ir_key_scan_pkg::*;
    logic float_r = 1'b0;
    wire logic cmd_hit = key_on && strobe_oe[key_s];
    wire logic sys_hit = link_on && strobe_oe[link_s];
    always @(posedge hclk) float_r <= ~float_r;
    // Pulled-up pins rest high, unpulled ones wander
    always_comb begin
        for (int i = 0; i < NUM_CMD_SENSE; i++) begin
            cmd_sense[i] = (cmd_hit && key_x == i) ? 1'b0 : (cmd_pullup_en | float_r);
        end
        for (int i = 0; i < NUM_SYS_SENSE; i++) begin
            sys_sense[i] = (sys_hit && link_z == i) ? 1'b0 : (sys_pullup_en | float_r);
        end
        strobe_pins = ~strobe_oe;
    end
endmodule

/* File: test/test_ir_key_scan_tx.sv */
// Bench: three presses from a table, then debounce, test, enable and reset cases.
// Assumes the key matrix model and the bound pin checker.
`timescale 1ns/1ps
module test_ir_key_scan_tx;
    import ir_key_scan_pkg::*;
    localparam int BC = 768;
    localparam int HALF = BC / 2;
    typedef struct {
        logic mode;
        logic [2:0] x;
        logic [2:0] s;
        logic [1:0] z;
        logic [2:0] zs;
        logic [4:0] sys;
        logic [5:0] cmd;
    } row_type;
    row_type rows [3] = '{'{1'b0, 3'd2, 3'd5, 2'd0, 3'd0, 5'd0, 6'd21},
        '{1'b1, 3'd7, 3'd6, 2'd1, 3'd3, 5'd11, 6'd62}, '{1'b0, 3'd0, 3'd0, 2'd2, 3'd4, 5'd20, 6'd63}};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic mode = 1'b0, spd = 1'b1, rdo = 1'b0, res_pin = 1'b0, key_on = 1'b0, link_on = 1'b0;
    logic [2:0] key_x = '0, key_s = '0, link_s = '0;
    logic [1:0] link_z = '0;
    logic hreadyout, cmd_pu, sys_pu, data_out;
    logic [31:0] hrdata;
    logic [7:0] cmd_sense, oe, pins;
    logic [3:0] sys_sense;
    int n_errors = 0;
    int n_checks = 0;
    always #12.5 hclk = ~hclk;
    ir_key_scan_tx #(.BIT_CYCLES(BC)) i_ir_key_scan_tx (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .system_mode_select(mode),
        .scan_speedup_test(spd), .latch_readout_speedup_test(rdo), .resonator_pin(res_pin),
        .cmd_sense(cmd_sense), .sys_sense(sys_sense), .scan_strobe_outputs_in(pins),
        .scan_strobe_outputs_out(), .scan_strobe_outputs_oe(oe), .cmd_pullup_en(cmd_pu),
        .sys_pullup_en(sys_pu), .osc_hold(), .data_out(data_out), .carrier_modulated_output());
    key_matrix_model i_key_matrix_model (.hclk(hclk), .strobe_oe(oe), .cmd_pullup_en(cmd_pu),
        .sys_pullup_en(sys_pu), .key_on(key_on), .key_x(key_x), .key_s(key_s), .link_on(link_on),
        .link_z(link_z), .link_s(link_s), .cmd_sense(cmd_sense), .sys_sense(sys_sense), .strobe_pins(pins));
    ////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] d;
        bus(1'b0, 32'(a), '0, d);
        check(d & m, exp);
    endtask
    task automatic wait_state(input logic [2:0] st);
        logic [31:0] d;
        d = '1;
        for (int n = 0; n < 20000 && d[2:0] !== st; n++) bus(1'b0, 32'(ADDR_STATUS), '0, d);
        check(32'(d[2:0]), 32'(st));
    endtask
    task automatic complete_run;
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge hclk);
        n_errors++;
        complete_run;
    end
    initial begin
        logic [31:0] d;
        logic [11:0] code;
        logic tog;
        tog = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[r]) begin
            @(posedge hclk);
            mode <= rows[r].mode;
            key_x <= rows[r].x;
            key_s <= rows[r].s;
            link_z <= rows[r].z;
            link_s <= rows[r].zs;
            link_on <= (rows[r].sys != 5'h00);
            key_on <= (rows[r].cmd != ALL_ONES_CMD);
            code = {tog, rows[r].sys, rows[r].cmd};
            wait_state(3'd3);
            repeat (HALF / 2) @(posedge hclk);
            for (int i = 0; i < 24; i++) begin
                check(32'(data_out), 32'(code[11 - i / 2] ^ (i % 2 == 0)));
                repeat (HALF) @(posedge hclk);
            end
            wait_state(3'd4);
            rd_chk(ADDR_CODE, 32'(code), 32'hFFF);
            {key_on, link_on} <= 2'b00;
            tog = ~tog;
            rd_chk(ADDR_STATUS, 32'({rows[r].mode, 1'b0, tog, 3'd0}), 32'h3F);
        end
        // Debounce cut short
        mode <= 1'b0;
        key_on <= 1'b1;
        repeat (5000) @(posedge hclk);
        rd_chk(ADDR_STATUS, 32'h01, 32'h17);
        key_on <= 1'b0;
        rd_chk(ADDR_STATUS, 32'({tog, 3'd0}), 32'h1F);
        // Test initialisation with key held
        key_on <= 1'b1;
        repeat (100) @(posedge hclk);
        rdo <= 1'b1;
        res_pin <= 1'b1;
        rd_chk(ADDR_STATUS, 32'h0, 32'h17);
        key_on <= 1'b0;
        rdo <= 1'b0;
        res_pin <= 1'b0;
        // Disabled block ignores a press
        bus(1'b1, 32'(ADDR_CTRL), 32'h0, d);
        key_on <= 1'b1;
        repeat (50) @(posedge hclk);
        rd_chk(ADDR_STATUS, 32'h0, 32'h07);
        rd_chk(ADDR_CTRL, 32'h0, '1);
        key_on <= 1'b0;
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(ADDR_CTRL, 32'h1, '1);
        rd_chk(ADDR_STATUS, 32'h0, '1);
        rd_chk(ADDR_CODE, 32'h0, '1);
        rd_chk(8'h0C, 32'h0, '1);
        complete_run;
    end
endmodule
